// [shared/awt_pkg.sv]
// package: register map, field layout and reset values for the adc window/mux/tempcal block
package awt_pkg;
   // register indices on the AHB-Lite slave; byte address is four times the index
   localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH  = 8'h86;
   localparam logic [7:0] ADDR_TEMP_OFFSET_LOW   = 8'h88;
   localparam logic [7:0] ADDR_IRQ_STATUS        = 8'h90;
   localparam logic [7:0] ADDR_IRQ_MASK          = 8'h94;
   localparam logic [7:0] ADDR_INPUT_CHANNEL_SEL = 8'hbb;
   localparam logic [7:0] ADDR_UPPER_LIMIT_LOW   = 8'hc3;
   localparam logic [7:0] ADDR_UPPER_LIMIT_HIGH  = 8'hc4;
   localparam logic [7:0] ADDR_LOWER_LIMIT_LOW   = 8'hc5;
   localparam logic [7:0] ADDR_LOWER_LIMIT_HIGH  = 8'hc6;
   localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'he8;
   // index to byte address scale and address width (several printed offsets are not word aligned)
   localparam int        BYTE_ADDR_SCALE        = 4;
   localparam int        ADDR_W                 = 10;
   // reset values
   localparam logic [7:0] RST_UPPER_LIMIT        = 8'hff;
   localparam logic [7:0] RST_LOWER_LIMIT        = 8'h00;
   localparam logic [4:0] RST_CHANNEL_SEL        = 5'h1f;
   // channel select codes
   localparam logic [4:0] CHAN_TEMP_SENSOR       = 5'h10;
   localparam logic [4:0] CHAN_SUPPLY            = 5'h11;
   localparam int        CHAN_SEL_W             = 5;
   localparam int        NUM_PORT_PINS          = 16;
   // field positions
   localparam int        WINDOW_FLAG_BIT        = 3;
   localparam int        IRQ_WINDOW_BIT         = 0;
   localparam int        IRQ_CONV_BIT           = 1;
   localparam int        TEMP_OFFSET_VALUE_LOW_LSB           = 6;
   // transfer kinds
   localparam logic [1:0] HTRANS_NONSEQ          = 2'h2;
   localparam logic [2:0] HSIZE_WORD             = 3'h2;
   localparam logic [1:0] HRESP_OKAY             = 2'h0;
endpackage : awt_pkg

// [verilog/awt_adc_window.sv]
// adc window detector, input mux select and temperature offset calibration registers
//
// Function
// - lower limit high byte read/write at 0xC6, resets to zero
// - lower limit low byte read/write at 0xC5, forms 16-bit compare value
// - normal limits: flag when result strictly between upper and lower values
// - inverted limits: flag when result below greater-than or above less-than
// - result compared as unsigned integer
// - compare full 16-bit result word, whatever the justification
// - five-bit select: port pins, then sensor, supply, then no input
// - channel select at 0xBB, upper bits read zero, resets to all ones
// - offset registers hold production reading of sensor at zero degrees
// - offset left justified, bits 9:2 in high byte at 0x86, part dependent
// - one offset lsb equals one converter result lsb
// - window flag reported in converter control bit 3, pollable or interrupt
// - greater-than limit at 0xC4/0xC3, each resets to all ones
`timescale 1ns/10ps
module awt_adc_window
   import awt_pkg::*;
#(
   parameter logic [9:0] TEMP_OFFSET_CAL = 10'h000  // arbitrary, trimmed per part in production
)(
   input  wire logic                  ref_clk,
   input  wire logic                  sys_rst,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic      [1:0]            hresp,
   input  wire logic                  convDone,
   input  wire logic [15:0]           convResult,
   output logic      [CHAN_SEL_W-1:0] channelSel,
   output logic      [NUM_PORT_PINS-1:0] portPinSel,
   output logic                       tempSensorSel,
   output logic                       supplySel,
   output logic                       windowCompareFlag,
   output logic                       irq
);
   // bus data phase state
   logic                  wrPend_q, wrPend_d;
   logic [ADDR_W-1:0]     wrAddr_q, wrAddr_d;
   logic [31:0]           rdData_q, rdData_d;
   // register state
   logic [7:0]            lowerHigh_q, lowerHigh_d;
   logic [7:0]            lowerLow_q, lowerLow_d;
   logic [7:0]            upperHigh_q, upperHigh_d;
   logic [7:0]            upperLow_q, upperLow_d;
   logic [4:0]            chanSel_q, chanSel_d;
   logic [9:0]            tempOffset_q, tempOffset_d;
   logic [1:0]            irqStatus_q, irqStatus_d;
   logic [1:0]            irqMask_q, irqMask_d;
   logic                  offsetLoaded_q, offsetLoaded_d;

   logic                  addrPhase;
   logic [15:0]           lowerLimit;
   logic [15:0]           upperLimit;
   logic                  windowHit;
   logic [1:0]            irqEvents;

   // word address: printed offsets are indices, byte address is four times the index
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = ADDR_W'(idx) * ADDR_W'(BYTE_ADDR_SCALE);
   endfunction : reg_addr

   function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a);
      read_mux = 32'h0000_0000;
      if (a == reg_addr(ADDR_LOWER_LIMIT_HIGH)) read_mux = {24'h00_0000, lowerHigh_q};
      else if (a == reg_addr(ADDR_LOWER_LIMIT_LOW)) read_mux = {24'h00_0000, lowerLow_q};
      else if (a == reg_addr(ADDR_UPPER_LIMIT_HIGH)) read_mux = {24'h00_0000, upperHigh_q};
      else if (a == reg_addr(ADDR_UPPER_LIMIT_LOW)) read_mux = {24'h00_0000, upperLow_q};
      else if (a == reg_addr(ADDR_INPUT_CHANNEL_SEL)) read_mux = {27'h000_0000, chanSel_q};
      else if (a == reg_addr(ADDR_TEMP_OFFSET_HIGH)) read_mux = {24'h00_0000, tempOffset_q[9:2]};
      else if (a == reg_addr(ADDR_TEMP_OFFSET_LOW)) read_mux = {24'h00_0000, tempOffset_q[1:0], 6'h00};
      else if (a == reg_addr(ADDR_CONVERTER_CONTROL)) read_mux = {28'h000_0000, irqStatus_q[IRQ_WINDOW_BIT], 3'h0};
      else if (a == reg_addr(ADDR_IRQ_STATUS)) read_mux = {30'h0000_0000, irqStatus_q};
      else if (a == reg_addr(ADDR_IRQ_MASK)) read_mux = {30'h0000_0000, irqMask_q};
   endfunction : read_mux

   assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
   assign lowerLimit = {lowerHigh_q, lowerLow_q};
   assign upperLimit = {upperHigh_q, upperLow_q};

   // unsigned compare on the raw 16-bit word works for either justification
   always_comb begin
      if (upperLimit < lowerLimit) begin
         windowHit = (convResult > upperLimit) && (convResult < lowerLimit);
      end else begin
         windowHit = (convResult < upperLimit) || (convResult > lowerLimit);
      end
   end

   assign irqEvents = {convDone, convDone && windowHit};

   always_comb begin
      wrPend_d       = addrPhase && hwrite;
      wrAddr_d       = addrPhase ? haddr[ADDR_W-1:0] : wrAddr_q;
      rdData_d       = (addrPhase && !hwrite) ? read_mux(haddr[ADDR_W-1:0]) : 32'h0000_0000;
      lowerHigh_d    = lowerHigh_q;
      lowerLow_d     = lowerLow_q;
      upperHigh_d    = upperHigh_q;
      upperLow_d     = upperLow_q;
      chanSel_d      = chanSel_q;
      tempOffset_d   = tempOffset_q;
      irqMask_d      = irqMask_q;
      irqStatus_d    = irqStatus_q;
      offsetLoaded_d = 1'b1;
      // production value is captured by a clocked load after reset release, not by the reset itself
      if (!offsetLoaded_q) begin
         tempOffset_d = TEMP_OFFSET_CAL;
      end
      if (wrPend_q) begin
         if (wrAddr_q == reg_addr(ADDR_LOWER_LIMIT_HIGH)) lowerHigh_d = hwdata[7:0];
         if (wrAddr_q == reg_addr(ADDR_LOWER_LIMIT_LOW)) lowerLow_d = hwdata[7:0];
         if (wrAddr_q == reg_addr(ADDR_UPPER_LIMIT_HIGH)) upperHigh_d = hwdata[7:0];
         if (wrAddr_q == reg_addr(ADDR_UPPER_LIMIT_LOW)) upperLow_d = hwdata[7:0];
         if (wrAddr_q == reg_addr(ADDR_INPUT_CHANNEL_SEL)) chanSel_d = hwdata[4:0];
         if (wrAddr_q == reg_addr(ADDR_TEMP_OFFSET_HIGH)) tempOffset_d[9:2] = hwdata[7:0];
         if (wrAddr_q == reg_addr(ADDR_TEMP_OFFSET_LOW)) tempOffset_d[1:0] = hwdata[7:TEMP_OFFSET_VALUE_LOW_LSB];
         if (wrAddr_q == reg_addr(ADDR_IRQ_MASK)) irqMask_d = hwdata[1:0];
         if (wrAddr_q == reg_addr(ADDR_IRQ_STATUS)) irqStatus_d = irqStatus_d & ~hwdata[1:0];
         // writing zero to the control flag clears it, as the flag bit is read/write there
         if (wrAddr_q == reg_addr(ADDR_CONVERTER_CONTROL) && !hwdata[WINDOW_FLAG_BIT]) begin
            irqStatus_d[IRQ_WINDOW_BIT] = 1'b0;
         end
      end
      irqStatus_d = irqStatus_d | irqEvents; // set wins over clear
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wrPend_q       <= 1'b0;
         wrAddr_q       <= '0;
         rdData_q       <= 32'h0000_0000;
         lowerHigh_q    <= RST_LOWER_LIMIT;
         lowerLow_q     <= RST_LOWER_LIMIT;
         upperHigh_q    <= RST_UPPER_LIMIT;
         upperLow_q     <= RST_UPPER_LIMIT;
         chanSel_q      <= RST_CHANNEL_SEL;
         tempOffset_q   <= 10'h000;
         irqStatus_q    <= 2'h0;
         irqMask_q      <= 2'h0;
         offsetLoaded_q <= 1'b0;
      end else begin
         wrPend_q       <= wrPend_d;
         wrAddr_q       <= wrAddr_d;
         rdData_q       <= rdData_d;
         lowerHigh_q    <= lowerHigh_d;
         lowerLow_q     <= lowerLow_d;
         upperHigh_q    <= upperHigh_d;
         upperLow_q     <= upperLow_d;
         chanSel_q      <= chanSel_d;
         tempOffset_q   <= tempOffset_d;
         irqStatus_q    <= irqStatus_d;
         irqMask_q      <= irqMask_d;
         offsetLoaded_q <= offsetLoaded_d;
      end
   end

   // mux decode: codes past the supply select nothing
   always_comb begin
      portPinSel    = '0;
      tempSensorSel = (chanSel_q == CHAN_TEMP_SENSOR);
      supplySel     = (chanSel_q == CHAN_SUPPLY);
      if (!chanSel_q[4]) begin
         portPinSel[chanSel_q[3:0]] = 1'b1;
      end
   end

   assign channelSel        = chanSel_q;
   assign windowCompareFlag = irqStatus_q[IRQ_WINDOW_BIT];
   assign irq               = |(irqStatus_q & irqMask_q);
   assign hrdata            = rdData_q;
   assign hreadyout         = 1'b1;
   assign hresp             = HRESP_OKAY;

   chk_flag_on_hit: assert property (@(posedge ref_clk) disable iff (sys_rst)
      convDone && windowHit |=> windowCompareFlag) else $error("window hit did not set flag");
   chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
      windowCompareFlag && !wrPend_q |=> windowCompareFlag) else $error("flag dropped without write");
   chk_inside_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (upperLimit < lowerLimit) && convDone && (convResult <= upperLimit) && !windowCompareFlag
      |=> !windowCompareFlag) else $error("inside window flagged outside");
   chk_outside_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (upperLimit >= lowerLimit) && convDone && (convResult > lowerLimit) |=> windowCompareFlag)
      else $error("outside window missed");
   chk_chan_reset: assert property (@(posedge ref_clk) $fell(sys_rst) |-> chanSel_q == 5'h1f)
      else $error("channel select reset wrong");
   chk_limit_reset: assert property (@(posedge ref_clk) $fell(sys_rst) |-> lowerLimit == 16'h0000
      && upperLimit == 16'hffff) else $error("limit reset wrong");
   chk_lower_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wrPend_q && wrAddr_q == reg_addr(ADDR_LOWER_LIMIT_LOW) |=> lowerLow_q == $past(hwdata[7:0]))
      else $error("lower limit low write lost");
   chk_mux_onehot: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $onehot0({portPinSel, tempSensorSel, supplySel}) && ((chanSel_q < 5'h12) || (!tempSensorSel
      && !supplySel && portPinSel == '0))) else $error("mux decode wrong");
   chk_offset_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
      addrPhase && !hwrite && haddr[ADDR_W-1:0] == reg_addr(ADDR_TEMP_OFFSET_HIGH)
      |=> hrdata[7:0] == tempOffset_q[9:2]) else $error("offset high read wrong");
   cov_hit: cover property (@(posedge ref_clk) convDone && windowHit);
   cov_irq: cover property (@(posedge ref_clk) irq);
   cov_sensor: cover property (@(posedge ref_clk) tempSensorSel);
endmodule : awt_adc_window

// [tb/awt_adc_window_tb.sv]
// self-checking testbench for the adc window detector, input select and offset registers
`timescale 1ns/10ps
module awt_adc_window_tb;
   import awt_pkg::*;
   localparam logic [9:0] CAL = 10'h2b7;  // arbitrary per-part offset
   logic        ref_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, convDone = 1'b0;
   logic        rdPh = 1'b0, hreadyout, tempSensorSel, supplySel, windowCompareFlag, irq;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdq[$], mq[$], lfsr = 32'h4213, v;
   logic [15:0] convResult = 16'h0, gt, lt, r, portPinSel;
   logic [1:0]  htrans = 2'h0, hresp;
   logic [2:0]  hsize = 3'h0;
   logic [4:0]  channelSel;
   logic [15:0] pairs[10] = '{16'h0040, 16'h0080, 16'h0080, 16'h0040, 16'h1000, 16'h2000, 16'h2000, 16'h1000,
                              16'h0080, 16'h0080};
   logic [15:0] vec[10] = '{16'h003f, 16'h0040, 16'h0041, 16'h007f, 16'h0080, 16'h0081, 16'h0000, 16'hffc0,
                            16'h1040, 16'h2040};
   logic [7:0]  rwIdx[5] = '{ADDR_UPPER_LIMIT_LOW, ADDR_UPPER_LIMIT_HIGH, ADDR_LOWER_LIMIT_LOW,
                             ADDR_LOWER_LIMIT_HIGH, ADDR_TEMP_OFFSET_HIGH};
   int          fails = 0, cmp_count = 0;

   awt_adc_window #(.TEMP_OFFSET_CAL(CAL)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .convDone(convDone), .convResult(convResult),
      .channelSel(channelSel), .portPinSel(portPinSel), .tempSensorSel(tempSensorSel), .supplySel(supplySel),
      .windowCompareFlag(windowCompareFlag), .irq(irq));

   initial forever #2.5 ref_clk = ~ref_clk;

   function automatic logic [31:0] nextRand();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : nextRand

   // expected window outcome; equal limits fall into outside mode
   function automatic logic win(input logic [15:0] x);
      return (gt < lt) ? (x > gt && x < lt) : (x < gt || x > lt);
   endfunction : win

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one single transfer; entered just after a rising edge, leaves just after one
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n = 0;
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1 && n++ < 50) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdPh <= !wr;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1 && n++ < 100) @(posedge ref_clk);
      rdPh <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [31:0] ex, input logic [31:0] m = 32'hffffffff);
      rdq.push_back(ex & m);
      mq.push_back(m);
      bus(1'b0, idx, 32'h0);
   endtask : rd

   task automatic conv(input logic [15:0] x, input logic ex);
      convResult <= x;
      convDone <= 1'b1;
      @(posedge ref_clk);
      convDone <= 1'b0;
      @(posedge ref_clk);
      #1 check("windowCompareFlag", {31'h0, windowCompareFlag}, {31'h0, ex});
      @(posedge ref_clk);
   endtask : conv

   task automatic chkIrq(input logic ex);
      @(posedge ref_clk);
      #1 check("irq", {31'h0, irq}, {31'h0, ex});
      @(posedge ref_clk);
   endtask : chkIrq

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // read data is compared at the edge that closes the data phase
   always @(posedge ref_clk) begin
      if (rdPh && hreadyout === 1'b1) begin
         check("hrdata", hrdata & mq[0], rdq[0]);
         check("hresp", {30'h0, hresp}, {30'h0, HRESP_OKAY});
         void'(rdq.pop_front());
         void'(mq.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      fails = fails + 1;
      tally_and_finish();
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd(ADDR_LOWER_LIMIT_HIGH, 32'h0);
      rd(ADDR_LOWER_LIMIT_LOW, 32'h0);
      rd(ADDR_UPPER_LIMIT_HIGH, 32'hff);
      rd(ADDR_UPPER_LIMIT_LOW, 32'hff);
      rd(ADDR_INPUT_CHANNEL_SEL, 32'h1f);
      rd(ADDR_TEMP_OFFSET_HIGH, {24'h0, CAL[9:2]});
      rd(ADDR_TEMP_OFFSET_LOW, {24'h0, CAL[1:0], 6'h0});
      rd(8'h40, 32'h0);
      $display("test reset_values done");
      for (int i = 0; i < 5; i++) begin
         v = nextRand();
         wr(rwIdx[i], v);
         rd(rwIdx[i], {24'h0, v[7:0]});
      end
      wr(ADDR_INPUT_CHANNEL_SEL, 32'hff);
      rd(ADDR_INPUT_CHANNEL_SEL, 32'h1f);
      for (int c = 0; c < 32; c++) begin
         wr(ADDR_INPUT_CHANNEL_SEL, c);
         #1 check("channelSel", {27'h0, channelSel}, c);
         check("portPinSel", {16'h0, portPinSel}, (c < 16) ? (32'h1 << c) : 32'h0);
         check("tempSensorSel", {31'h0, tempSensorSel}, {31'h0, c == 16});
         check("supplySel", {31'h0, supplySel}, {31'h0, c == 17});
         @(posedge ref_clk);
      end
      $display("test registers_and_select done");
      for (int p = 0; p < 5; p++) begin
         gt = pairs[2*p];
         lt = pairs[2*p+1];
         wr(ADDR_UPPER_LIMIT_HIGH, gt[15:8]);
         wr(ADDR_UPPER_LIMIT_LOW, gt[7:0]);
         wr(ADDR_LOWER_LIMIT_HIGH, lt[15:8]);
         wr(ADDR_LOWER_LIMIT_LOW, lt[7:0]);
         for (int k = 0; k < 16; k++) begin
            v = nextRand();
            r = (k < 10) ? vec[k] : (v[31] ? {8'h0, v[7:0]} : v[15:0]);
            wr(ADDR_IRQ_STATUS, 32'h3);
            conv(r, win(r));
         end
      end
      $display("test window_compare done");
      conv(16'h0000, 1'b1);
      rd(ADDR_CONVERTER_CONTROL, 32'h8, 32'h8);
      wr(ADDR_CONVERTER_CONTROL, 32'h0);
      rd(ADDR_CONVERTER_CONTROL, 32'h0, 32'h8);
      wr(ADDR_IRQ_MASK, 32'h0);
      conv(16'h0000, 1'b1);
      chkIrq(1'b0);
      wr(ADDR_IRQ_MASK, 32'h1);
      chkIrq(1'b1);
      rd(ADDR_IRQ_STATUS, 32'h3);
      wr(ADDR_IRQ_STATUS, 32'h1);
      chkIrq(1'b0);
      wr(ADDR_IRQ_MASK, 32'h2);
      chkIrq(1'b1);
      $display("test sticky_and_irq done");
      tally_and_finish();
   end
endmodule : awt_adc_window_tb
